// >>> uart_spi_pkg.sv
// Constants shared by the command-driven serial port and its baud divider.
// Assumes the includer imports it whole; no clocks or resets live here.
package uart_spi_pkg;
  // ==========================================================
  // Command framing
  localparam int SPI_BITS = 16;
  localparam int CMD_BITS = 8;
  localparam int CMD_REG_BIT = 4;
  localparam int CMD_WR_BIT = 3;
  // ==========================================================
  // Register addresses
  localparam logic [2:0] ADDR_STATUS = 3'h0;
  localparam logic [2:0] ADDR_CTRL1 = 3'h1;
  localparam logic [2:0] ADDR_CTRL2 = 3'h2;
  localparam logic [2:0] ADDR_BAUD = 3'h3;
  localparam logic [2:0] ADDR_CTRL3 = 3'h4;
  // ==========================================================
  // Control field positions
  localparam int C1_EN = 7;
  localparam int C1_BNO = 6;
  localparam int C1_PREN = 5;
  localparam int C1_PRT = 4;
  localparam int C1_STOPS = 3;
  localparam int C1_TXBRK = 2;
  localparam int C1_RX8 = 1;
  localparam int C1_TX8 = 0;
  localparam int C2_TRANSMIT_ENABLE = 7;
  localparam int C2_RECEIVE_ENABLE = 6;
  localparam int C2_RIE = 2;
  localparam int C2_TIIE = 1;
  localparam int C2_TEIE = 0;
  localparam int C3_URST = 7;
  // ==========================================================
  // Reset values
  localparam logic [7:0] STATUS_RESET = 8'h0b;
  localparam logic [7:0] CTRL1_RESET = 8'h00;
  localparam logic [7:0] CTRL2_RESET = 8'h00;
  localparam logic [7:0] BAUD_RESET = 8'h00;
  localparam logic [7:0] CTRL3_RESET = 8'h00;
  // ==========================================================
  // Bit timing: last oversample tick of a bit, mid-bit sample point, data bits per word
  localparam logic [3:0] OVS_LAST = 4'hf;
  localparam logic [3:0] OVS_MID = 4'h7;
  localparam logic [3:0] BITS_STD = 4'h8;
  localparam logic [3:0] BITS_LONG = 4'h9;
endpackage

// >>> baud_tick_gen.sv
// Oversample tick source: one pulse every divisor+1 system clocks.
// Assumes divisor comes from a register on the same clock.
`timescale 1ns/1ps
module baud_tick_gen (
  input wire logic i_clk_sys, // System clock
  input wire logic i_rst, // Sync reset, high
  input wire logic i_run, // Count while high
  input wire logic [7:0] i_divisor, // Clocks per tick minus one
  output logic o_tick // One-cycle tick
);
  import uart_spi_pkg::*;
  logic [7:0] cnt_r, cnt_nxt;
  logic tick_r, tick_nxt;
  // ==========================================================
  // Divider; a divisor change takes effect at once, compared against the running count
  always_comb begin
    cnt_nxt = cnt_r + 8'h01;
    tick_nxt = 1'b0;
    if (!i_run) begin
      cnt_nxt = 8'h00;
    end else if (cnt_r >= i_divisor) begin
      cnt_nxt = 8'h00;
      tick_nxt = 1'b1;
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      cnt_r <= 8'h00;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end
  assign o_tick = tick_r;
endmodule

// >>> spi_attached_uart_module.sv
// Serial port reached through a 16-bit command/data slave serial link.
// Assumes link pins and RX come from outside the clock domain.
// Contract
// - Select must stay low; early rise discards
// - Command byte then data byte each way
// - Input sampled on serial clock rise
// - Output changes on serial clock fall
// - Select high: link idle, output released
// - Write executes after 16 bits, select high
// - Read executes after command; abort anytime
// - TX drives only when enabled globally too
// - RX listens only when enabled globally too
// - Holding byte moves to shifter, LSB first
// - Receive shifter LSB first, full moves out
// - One shared data register both ways
// - Eight or nine bits; overrun, framing errors
// - Command decode: class, direction, address
// - Status 0, controls 1,2,4, divisor 3
// - Status read-only, resets to 0x0b
// - Parity flag set, cleared by read sequence
// - Own interrupt for receive or transmit
`timescale 1ns/1ps
module spi_attached_uart_module (
  input wire logic i_clk_sys, // System clock
  input wire logic i_rst, // Sync reset, high
  input wire logic i_slave_select_n, // Link select, low
  input wire logic i_sck, // Link clock
  input wire logic i_serial_in_line, // Link data in
  output logic o_serial_out_line, // Link data out
  output logic o_serial_out_oe_n, // Link out enable, low
  input wire logic i_rx, // Serial receive pin
  output logic o_tx, // Serial transmit pin
  output logic o_tx_oe_n, // Transmit enable, low
  output logic o_irq // Interrupt, high
);
  import uart_spi_pkg::*;
  typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_t;
  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_t;

  // ==========================================================
  // Command decode helpers
  function automatic logic cmd_is_read(input logic [7:0] c);
    cmd_is_read = (c[7:5] == 3'h0) && !c[CMD_WR_BIT];
  endfunction
  function automatic logic cmd_is_write(input logic [7:0] c);
    cmd_is_write = (c[7:5] == 3'h0) && c[CMD_WR_BIT];
  endfunction

  // ==========================================================
  // Input synchronisers: select, clock, data, rx
  logic [3:0] sync1_r, sync2_r;
  logic sck_d_r;
  logic s_scs_n, s_sck, s_sdi, s_rx, sck_rise, sck_fall;
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      sync1_r <= 4'hf;
      sync2_r <= 4'hf;
      sck_d_r <= 1'b1;
    end else begin
      sync1_r <= {i_rx, i_serial_in_line, i_sck, i_slave_select_n};
      sync2_r <= sync1_r;
      sck_d_r <= sync2_r[1];
    end
  end
  assign s_scs_n = sync2_r[0];
  assign s_sck = sync2_r[1];
  assign s_sdi = sync2_r[2];
  assign s_rx = sync2_r[3];
  assign sck_rise = s_sck && !sck_d_r;
  assign sck_fall = !s_sck && sck_d_r;

  // ==========================================================
  // Register file state
  logic [7:0] ctrl1_r, ctrl1_nxt, ctrl2_r, ctrl2_nxt, baud_r, baud_nxt;
  logic [7:0] ctrl3_r, ctrl3_nxt, data_r, data_nxt;
  logic rx8_r, rx8_nxt, armed_r, armed_nxt, irq_r, irq_nxt;
  logic parity_error_flag_r, parity_error_flag_nxt, nf_r, ferr_r, ferr_nxt, oerr_r, oerr_nxt;
  logic rxif_r, rxif_nxt, txif_r, txif_nxt;
  logic tidle, ridle, urst, tx_en, rx_en, tick, tx_load, rx_done;
  logic rx_ferr, rx_parity_error_flag_r, rx_parity_error_flag_nxt;
  logic [8:0] rx_shift_r, rx_shift_nxt;
  assign urst = ctrl3_r[C3_URST];
  assign tx_en = ctrl1_r[C1_EN] && ctrl2_r[C2_TRANSMIT_ENABLE] && !urst;
  assign rx_en = ctrl1_r[C1_EN] && ctrl2_r[C2_RECEIVE_ENABLE] && !urst;
  assign nf_r = 1'b0;

  // ==========================================================
  // Link shifter: sample on rise, drive on fall
  logic [4:0] bit_cnt_r, bit_cnt_nxt;
  logic [15:0] shin_r, shin_nxt;
  logic [7:0] shout_r, shout_nxt, rd_cmd, rd_val;
  logic sdo_r, sdo_nxt, sdo_oe_n_r, sdo_oe_n_nxt, rd_exec, wr_exec;
  assign rd_cmd = {shin_r[6:0], s_sdi};
  // Read value mux; reserved space reads zero
  always_comb begin
    case (rd_cmd[2:0])
      ADDR_STATUS: rd_val = {parity_error_flag_r, nf_r, ferr_r, oerr_r, ridle, rxif_r, tidle, txif_r};
      ADDR_CTRL1: rd_val = {ctrl1_r[7:2], rx8_r, ctrl1_r[C1_TX8]};
      ADDR_CTRL2: rd_val = ctrl2_r;
      ADDR_BAUD: rd_val = baud_r;
      ADDR_CTRL3: rd_val = ctrl3_r;
      default: rd_val = 8'h00;
    endcase
    if (!rd_cmd[CMD_REG_BIT]) begin
      rd_val = data_r;
    end
  end
  always_comb begin
    bit_cnt_nxt = bit_cnt_r;
    shin_nxt = shin_r;
    shout_nxt = shout_r;
    sdo_nxt = sdo_r;
    sdo_oe_n_nxt = 1'b0;
    rd_exec = 1'b0;
    wr_exec = 1'b0;
    if (s_scs_n) begin
      bit_cnt_nxt = 5'h00;
      sdo_oe_n_nxt = 1'b1;
      sdo_nxt = 1'b0;
      // Only a complete write frame executes; abort leaves count short
      if (bit_cnt_r == 5'(SPI_BITS) && cmd_is_write(shin_r[15:8])) begin
        wr_exec = 1'b1;
      end
    end else begin
      if (sck_rise && bit_cnt_r < 5'(SPI_BITS)) begin
        shin_nxt = {shin_r[14:0], s_sdi};
        bit_cnt_nxt = bit_cnt_r + 5'h01;
        if (bit_cnt_r == 5'(CMD_BITS - 1) && cmd_is_read(rd_cmd)) begin
          rd_exec = 1'b1;
          shout_nxt = rd_val;
        end
      end
      if (sck_fall && bit_cnt_r >= 5'(CMD_BITS) && bit_cnt_r < 5'(SPI_BITS)) begin
        sdo_nxt = shout_r[7];
        shout_nxt = {shout_r[6:0], 1'b0};
      end
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      bit_cnt_r <= 5'h00;
      shin_r <= 16'h0000;
      shout_r <= 8'h00;
      sdo_r <= 1'b0;
      sdo_oe_n_r <= 1'b1;
    end else begin
      bit_cnt_r <= bit_cnt_nxt;
      shin_r <= shin_nxt;
      shout_r <= shout_nxt;
      sdo_r <= sdo_nxt;
      sdo_oe_n_r <= sdo_oe_n_nxt;
    end
  end
  assign o_serial_out_line = sdo_r;
  assign o_serial_out_oe_n = sdo_oe_n_r;

  // ==========================================================
  // Registers and flags; a hardware set beats a software clear
  logic wr_reg, wr_dat, rd_dat, clr_rx;
  assign wr_reg = wr_exec && shin_r[8 + CMD_REG_BIT];
  assign wr_dat = wr_exec && !shin_r[8 + CMD_REG_BIT];
  assign rd_dat = rd_exec && !rd_cmd[CMD_REG_BIT];
  assign clr_rx = armed_r && (wr_dat || rd_dat);
  always_comb begin
    ctrl1_nxt = ctrl1_r;
    ctrl2_nxt = ctrl2_r;
    baud_nxt = baud_r;
    ctrl3_nxt = ctrl3_r;
    data_nxt = data_r;
    rx8_nxt = rx8_r;
    armed_nxt = armed_r;
    parity_error_flag_nxt = parity_error_flag_r;
    ferr_nxt = ferr_r;
    oerr_nxt = oerr_r;
    rxif_nxt = rxif_r;
    txif_nxt = txif_r;
    if (wr_reg) begin
      case (shin_r[10:8])
        ADDR_CTRL1: ctrl1_nxt = {shin_r[7:2], 1'b0, shin_r[C1_TX8]};
        ADDR_CTRL2: ctrl2_nxt = shin_r[7:0];
        ADDR_BAUD: baud_nxt = shin_r[7:0];
        ADDR_CTRL3: ctrl3_nxt = {shin_r[C3_URST], 7'h00};
        default: ; // Status and reserved writes dropped
      endcase
    end
    if (rd_exec && rd_cmd[CMD_REG_BIT] && rd_cmd[2:0] == ADDR_STATUS) begin
      armed_nxt = 1'b1;
    end
    if (clr_rx) begin
      armed_nxt = 1'b0;
      parity_error_flag_nxt = 1'b0;
      ferr_nxt = 1'b0;
      oerr_nxt = 1'b0;
      rxif_nxt = 1'b0;
    end
    if (wr_dat) begin
      data_nxt = shin_r[7:0];
      txif_nxt = 1'b0;
    end
    if (tx_load || !tx_en) begin
      txif_nxt = 1'b1;
    end
    if (rx_done) begin
      if (rxif_r && !clr_rx) begin
        oerr_nxt = 1'b1;
      end else begin
        data_nxt = ctrl1_r[C1_BNO] ? rx_shift_r[7:0] : rx_shift_r[8:1];
        rx8_nxt = ctrl1_r[C1_BNO] && rx_shift_r[8];
        rxif_nxt = 1'b1;
        ferr_nxt = rx_ferr;
        parity_error_flag_nxt = rx_parity_error_flag_r && ctrl1_r[C1_PREN];
      end
    end
    if (urst) begin
      {parity_error_flag_nxt, ferr_nxt, oerr_nxt, rxif_nxt, armed_nxt} = 5'h00;
    end
    irq_nxt = (ctrl2_r[C2_RIE] && rxif_r) || (ctrl2_r[C2_TIIE] && tidle) ||
              (ctrl2_r[C2_TEIE] && txif_r);
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      ctrl1_r <= CTRL1_RESET;
      ctrl2_r <= CTRL2_RESET;
      baud_r <= BAUD_RESET;
      ctrl3_r <= CTRL3_RESET;
      data_r <= 8'h00;
      rx8_r <= 1'b0;
      armed_r <= 1'b0;
      irq_r <= 1'b0;
      parity_error_flag_r <= STATUS_RESET[7];
      ferr_r <= STATUS_RESET[5];
      oerr_r <= STATUS_RESET[4];
      rxif_r <= STATUS_RESET[2];
      txif_r <= STATUS_RESET[0];
    end else begin
      ctrl1_r <= ctrl1_nxt;
      ctrl2_r <= ctrl2_nxt;
      baud_r <= baud_nxt;
      ctrl3_r <= ctrl3_nxt;
      data_r <= data_nxt;
      rx8_r <= rx8_nxt;
      armed_r <= armed_nxt;
      irq_r <= irq_nxt;
      parity_error_flag_r <= parity_error_flag_nxt;
      ferr_r <= ferr_nxt;
      oerr_r <= oerr_nxt;
      rxif_r <= rxif_nxt;
      txif_r <= txif_nxt;
    end
  end
  assign o_irq = irq_r;

  baud_tick_gen u_baud (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_run(ctrl1_r[C1_EN]),
    .i_divisor(baud_r),
    .o_tick(tick)
  );

  // ==========================================================
  // Transmitter; parity is an extra bit after the data
  tx_state_t tx_st_r, tx_st_nxt;
  logic [8:0] tx_sh_r, tx_sh_nxt;
  logic [3:0] tx_bit_r, tx_bit_nxt, tx_ovs_r, tx_ovs_nxt, nbits;
  logic tx_par_r, tx_par_nxt, tx_line_r, tx_line_nxt, tx_oe_n_r;
  assign nbits = ctrl1_r[C1_BNO] ? BITS_LONG : BITS_STD;
  assign tidle = (tx_st_r == TX_IDLE) && txif_r;
  always_comb begin
    tx_st_nxt = tx_st_r;
    tx_sh_nxt = tx_sh_r;
    tx_bit_nxt = tx_bit_r;
    tx_ovs_nxt = tx_ovs_r;
    tx_par_nxt = tx_par_r;
    tx_load = 1'b0;
    if (tick) begin
      tx_ovs_nxt = tx_ovs_r + 4'h1;
    end
    case (tx_st_r)
      TX_IDLE: begin
        tx_ovs_nxt = 4'h0;
        if (tx_en && !txif_r) begin
          tx_load = 1'b1;
          tx_sh_nxt = {ctrl1_r[C1_TX8] && ctrl1_r[C1_BNO], data_r};
          tx_par_nxt = ^{ctrl1_r[C1_TX8] && ctrl1_r[C1_BNO], data_r};
          tx_bit_nxt = 4'h0;
          tx_st_nxt = TX_START;
        end
      end
      TX_START: if (tick && tx_ovs_r == OVS_LAST) tx_st_nxt = TX_DATA;
      TX_DATA: begin
        if (tick && tx_ovs_r == OVS_LAST) begin
          tx_sh_nxt = {1'b0, tx_sh_r[8:1]};
          tx_bit_nxt = tx_bit_r + 4'h1;
          if (tx_bit_r == nbits - 4'h1) begin
            tx_bit_nxt = 4'h0;
            tx_st_nxt = ctrl1_r[C1_PREN] ? TX_PAR : TX_STOP;
          end
        end
      end
      TX_PAR: if (tick && tx_ovs_r == OVS_LAST) tx_st_nxt = TX_STOP;
      TX_STOP: begin
        if (tick && tx_ovs_r == OVS_LAST) begin
          tx_bit_nxt = 4'h1;
          if (!ctrl1_r[C1_STOPS] || tx_bit_r != 4'h0) tx_st_nxt = TX_IDLE;
        end
      end
      default: tx_st_nxt = TX_IDLE;
    endcase
    if (!tx_en) tx_st_nxt = TX_IDLE;
    case (tx_st_r)
      TX_START: tx_line_nxt = 1'b0;
      TX_DATA: tx_line_nxt = tx_sh_r[0];
      TX_PAR: tx_line_nxt = tx_par_r ^ ctrl1_r[C1_PRT];
      default: tx_line_nxt = 1'b1;
    endcase
    if (ctrl1_r[C1_TXBRK]) tx_line_nxt = 1'b0;
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      tx_st_r <= TX_IDLE;
      tx_sh_r <= 9'h000;
      tx_bit_r <= 4'h0;
      tx_ovs_r <= 4'h0;
      tx_par_r <= 1'b0;
      tx_line_r <= 1'b1;
      tx_oe_n_r <= 1'b1;
    end else begin
      tx_st_r <= tx_st_nxt;
      tx_sh_r <= tx_sh_nxt;
      tx_bit_r <= tx_bit_nxt;
      tx_ovs_r <= tx_ovs_nxt;
      tx_par_r <= tx_par_nxt;
      tx_line_r <= tx_line_nxt;
      tx_oe_n_r <= !tx_en;
    end
  end
  assign o_tx = tx_line_r;
  assign o_tx_oe_n = tx_oe_n_r;

  // ==========================================================
  // Receiver: mid-bit sampling at the oversample rate
  rx_state_t rx_st_r, rx_st_nxt;
  logic [3:0] rx_bit_r, rx_bit_nxt, rx_ovs_r, rx_ovs_nxt;
  logic rx_par_r, rx_par_nxt, rx_line, rx_smp;
  assign rx_line = rx_en ? s_rx : 1'b1;
  assign rx_smp = tick && rx_ovs_r == OVS_LAST;
  assign ridle = rx_st_r == RX_IDLE;
  assign rx_ferr = !rx_line;
  always_comb begin
    rx_st_nxt = rx_st_r;
    rx_shift_nxt = rx_shift_r;
    rx_bit_nxt = rx_bit_r;
    rx_ovs_nxt = tick ? rx_ovs_r + 4'h1 : rx_ovs_r;
    rx_par_nxt = rx_par_r;
    rx_parity_error_flag_nxt = rx_parity_error_flag_r;
    rx_done = 1'b0;
    case (rx_st_r)
      RX_IDLE: begin
        rx_ovs_nxt = 4'h0;
        if (!rx_line) rx_st_nxt = RX_START;
      end
      RX_START: begin
        // A start bit gone by mid-bit is a glitch, not a frame
        if (tick && rx_ovs_r == OVS_MID) begin
          rx_ovs_nxt = 4'h0;
          rx_bit_nxt = 4'h0;
          rx_par_nxt = 1'b0;
          rx_st_nxt = rx_line ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA: begin
        if (rx_smp) begin
          rx_shift_nxt = {rx_line, rx_shift_r[8:1]};
          rx_par_nxt = rx_par_r ^ rx_line;
          rx_bit_nxt = rx_bit_r + 4'h1;
          if (rx_bit_r == nbits - 4'h1) rx_st_nxt = ctrl1_r[C1_PREN] ? RX_PAR : RX_STOP;
        end
      end
      RX_PAR: begin
        if (rx_smp) begin
          rx_parity_error_flag_nxt = rx_par_r ^ rx_line ^ ctrl1_r[C1_PRT];
          rx_st_nxt = RX_STOP;
        end
      end
      RX_STOP: begin
        if (rx_smp) begin
          rx_done = 1'b1;
          rx_st_nxt = RX_IDLE;
        end
      end
      default: rx_st_nxt = RX_IDLE;
    endcase
    if (rx_st_r == RX_IDLE) rx_parity_error_flag_nxt = 1'b0;
    if (!rx_en) rx_st_nxt = RX_IDLE;
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      rx_st_r <= RX_IDLE;
      rx_shift_r <= 9'h000;
      rx_bit_r <= 4'h0;
      rx_ovs_r <= 4'h0;
      rx_par_r <= 1'b0;
      rx_parity_error_flag_r <= 1'b0;
    end else begin
      rx_st_r <= rx_st_nxt;
      rx_shift_r <= rx_shift_nxt;
      rx_bit_r <= rx_bit_nxt;
      rx_ovs_r <= rx_ovs_nxt;
      rx_par_r <= rx_par_nxt;
      rx_parity_error_flag_r <= rx_parity_error_flag_nxt;
    end
  end

  // ==========================================================
  // Checks
  // Judged on the registers themselves, so a broken execute gate shows up
  property p_abort_discard;
    @(posedge i_clk_sys) disable iff (i_rst)
      $rose(s_scs_n) && bit_cnt_r != 5'(SPI_BITS) |=>
        $stable(ctrl1_r) && $stable(ctrl2_r) && $stable(baud_r) && $stable(ctrl3_r);
  endproperty
  a_abort_discard: assert property (p_abort_discard) else $error("short frame executed");
  property p_sdo_release;
    @(posedge i_clk_sys) disable iff (i_rst) s_scs_n |=> o_serial_out_oe_n;
  endproperty
  a_sdo_release: assert property (p_sdo_release) else $error("link out not released");
  property p_sdo_on_fall;
    @(posedge i_clk_sys) disable iff (i_rst)
      $changed(o_serial_out_line) |-> $past(sck_fall) || $past(s_scs_n);
  endproperty
  a_sdo_on_fall: assert property (p_sdo_on_fall) else $error("link out moved off fall");
  property p_sample_on_rise;
    @(posedge i_clk_sys) disable iff (i_rst)
      !s_scs_n && sck_rise && bit_cnt_r < 5'(SPI_BITS) |=> shin_r[0] == $past(s_sdi);
  endproperty
  a_sample_on_rise: assert property (p_sample_on_rise) else $error("input not sampled");
  property p_read_exec;
    @(posedge i_clk_sys) disable iff (i_rst) rd_exec |=> bit_cnt_r == 5'(CMD_BITS);
  endproperty
  a_read_exec: assert property (p_read_exec) else $error("read began at wrong bit");
  property p_tx_release;
    @(posedge i_clk_sys) disable iff (i_rst) !ctrl1_r[C1_EN] |=> o_tx_oe_n;
  endproperty
  a_tx_release: assert property (p_tx_release) else $error("tx driven while off");
  property p_rx_move;
    @(posedge i_clk_sys) disable iff (i_rst)
      rx_done && !rxif_r && !urst |=> rxif_r && !ridle == 1'b0;
  endproperty
  a_rx_move: assert property (p_rx_move) else $error("receive not transferred");
  property p_tx_start;
    @(posedge i_clk_sys) disable iff (i_rst)
      tx_load && !ctrl1_r[C1_TXBRK] |=> txif_r ##[1:300] !o_tx;
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("no start bit after load");
  property p_parity_error_flag_cause;
    @(posedge i_clk_sys) disable iff (i_rst) $rose(parity_error_flag_r) |-> $past(ctrl1_r[C1_PREN]);
  endproperty
  a_parity_error_flag_cause: assert property (p_parity_error_flag_cause) else $error("parity flag without parity");
endmodule

// >>> spi_master_model.sv
// ==========================================================
// Link master model: drives select, link clock and data in.
// Assumes the bench calls xfer, one frame at a time.
`timescale 1ns/1ps
module spi_master_model (
  input wire logic i_clk_sys, // System clock
  input wire logic i_so, // Link data from port
  input wire logic i_so_oe_n, // Port drives link, low
  output logic o_sel_n, // Link select, low
  output logic o_sck, // Link clock, idles high
  output logic o_sdi // Link data to port
);
  // Idle: deselected, clock parked high
  initial begin
    o_sel_n = 1'b1;
    o_sck = 1'b1;
    o_sdi = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask
  // ==========================================================
  // Frame engine; 4 system clocks a half gives the 32 ns link clock
  task automatic xfer(input logic [15:0] w, input int nbits, output logic [7:0] rd);
    logic [15:0] sh;
    sh = '0;
    hold(1);
    o_sel_n <= 1'b0; // Held low all frame
    hold(26); // Select setup before clock falls
    for (int i = 15; i > 15 - nbits; i--) begin
      o_sck <= 1'b0;
      o_sdi <= w[i]; // Command then data, stable before rise
      hold(4);
      sh = {sh[14:0], i_so_oe_n ? ~sh[0] : i_so}; // Taken before next fall
      o_sck <= 1'b1;
      hold(4);
    end
    o_sel_n <= 1'b1; // Raise after frame, or early to abandon
    o_sdi <= ~o_sdi; // Released line carries no stale bit
    hold(100); // Select high gap
    rd = sh[7:0];
  endtask
endmodule

// >>> tb.sv
// ==========================================================
// Self-checking bench for the command-driven serial port.
// Assumes baud 0: 16 system clocks per serial bit.
`timescale 1ns/1ps
module tb;
  import uart_spi_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  logic i_rx = 1'b1;
  logic sel_n, sck, serial_in_line, so, so_oe_n, tx, tx_oe_n, irq;
  logic [7:0] r;
  int bad_count = 0;
  int checks_done = 0;
  always #2 i_clk_sys = ~i_clk_sys;
  spi_attached_uart_module uut (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_slave_select_n(sel_n), .i_sck(sck), .i_serial_in_line(serial_in_line),
    .o_serial_out_line(so), .o_serial_out_oe_n(so_oe_n), .i_rx(i_rx),
    .o_tx(tx), .o_tx_oe_n(tx_oe_n), .o_irq(irq));
  spi_master_model m (.i_clk_sys(i_clk_sys), .i_so(so), .i_so_oe_n(so_oe_n),
    .o_sel_n(sel_n), .o_sck(sck), .o_sdi(serial_in_line));
  // ==========================================================
  // Helpers
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] x;
    m.xfer({c, d}, 16, x);
  endtask
  task automatic rd(input logic [7:0] c, output logic [7:0] d);
    m.xfer({c, 8'h00}, 16, d);
  endtask
  // Register command: class bit and direction bit over the address
  function automatic logic [7:0] rc(input logic w, input logic [2:0] a);
    return {3'h0, 1'h1, w, a};
  endfunction
  // Start, 8 data LSB first, optional parity, one stop
  task automatic rx_frame(input logic [7:0] d, input logic pe, input logic p, input logic st);
    i_rx <= 1'b0;
    cyc(16);
    for (int i = 0; i < 8; i++) begin
      i_rx <= d[i];
      cyc(16);
    end
    if (pe) begin
      i_rx <= p;
      cyc(16);
    end
    i_rx <= st;
    cyc(16);
    i_rx <= 1'b1;
    cyc(16);
  endtask
  // Sample the transmit line mid-bit, bounded wait for start
  task automatic tx_grab(output logic [7:0] d);
    for (int k = 0; k < 3000 && tx !== 1'b0; k++) @(posedge i_clk_sys);
    cyc(8);
    for (int i = 0; i < 8; i++) begin
      cyc(16);
      d[i] = tx;
    end
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset();
    check8({7'h0, tx_oe_n}, 8'h01);
    check8({7'h0, so_oe_n}, 8'h01);
    for (int a = 0; a < 5; a++) begin
      rd(rc(1'b0, a[2:0]), r);
      check8(r, a == 0 ? STATUS_RESET : 8'h00);
    end
  endtask
  task automatic t_regs();
    wr(rc(1'b1, ADDR_BAUD), 8'h5a);
    m.xfer({rc(1'b1, ADDR_BAUD), 8'h33}, 12, r);
    wr(8'h3b, 8'h77);
    rd(rc(1'b0, ADDR_BAUD), r);
    check8(r, 8'h5a);
    wr(rc(1'b1, ADDR_STATUS), 8'hff);
    rd(rc(1'b0, ADDR_STATUS), r);
    check8(r, STATUS_RESET);
    wr(rc(1'b1, ADDR_BAUD), 8'h00);
    wr(8'h0f, 8'hc3);
    rd(8'h05, r);
    check8(r, 8'hc3);
  endtask
  task automatic t_tx();
    wr(rc(1'b1, ADDR_CTRL1), 8'h80);
    wr(rc(1'b1, ADDR_CTRL2), 8'h80);
    check8({7'h0, tx_oe_n}, 8'h00);
    fork
      wr(8'h08, 8'ha5);
      tx_grab(r);
    join
    check8(r, 8'ha5);
  endtask
  task automatic t_rx();
    rx_frame(8'h3c, 1'b0, 1'b0, 1'b1);
    rd(rc(1'b0, ADDR_STATUS), r);
    check8({7'h0, r[2]}, 8'h00);
    wr(rc(1'b1, ADDR_CTRL2), 8'h44);
    rx_frame(8'h3c, 1'b0, 1'b0, 1'b1);
    check8({7'h0, irq}, 8'h01);
    rd(rc(1'b0, ADDR_STATUS), r);
    check8({7'h0, r[2]}, 8'h01);
    rd(8'h00, r);
    check8(r, 8'h3c);
    check8({7'h0, irq}, 8'h00);
  endtask
  task automatic t_err();
    wr(rc(1'b1, ADDR_CTRL1), 8'ha0);
    rx_frame(8'h01, 1'b1, 1'b0, 1'b1);
    rd(rc(1'b0, ADDR_STATUS), r);
    check8({7'h0, r[7]}, 8'h01);
    rd(8'h00, r);
    rd(rc(1'b0, ADDR_STATUS), r);
    check8({7'h0, r[7]}, 8'h00);
    rd(8'h00, r);
    rx_frame(8'h02, 1'b1, 1'b1, 1'b0);
    rd(rc(1'b0, ADDR_STATUS), r);
    check8({7'h0, r[5]}, 8'h01);
    // Second frame lands while the first is unread: overrun, data kept
    rx_frame(8'h04, 1'b1, 1'b1, 1'b1);
    rd(rc(1'b0, ADDR_STATUS), r);
    check8({7'h0, r[4]}, 8'h01);
    rd(8'h00, r);
    check8(r, 8'h02);
    // Nine-bit word: ninth bit rides in the parity slot, shows in bit 1
    wr(rc(1'b1, ADDR_CTRL1), 8'hc0);
    rx_frame(8'h5a, 1'b1, 1'b1, 1'b1);
    rd(8'h00, r);
    check8(r, 8'h5a);
    rd(rc(1'b0, ADDR_CTRL1), r);
    check8(r, 8'hc2);
  endtask
  // ==========================================================
  // Closing and sequencing
  task automatic report_and_stop();
    if (bad_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    cyc(60000);
    bad_count++;
    report_and_stop();
  end
  initial begin
    cyc(2);
    i_rst <= 1'b0;
    cyc(4);
    t_reset();
    t_regs();
    t_tx();
    t_rx();
    t_err();
    report_and_stop();
  end
endmodule
